// >>> fault_status_pkg.sv
// fault status word layout, encodings and fault classes
// assumes: shared by the stacking unit, its checker and the bench
package fault_status_pkg;
    localparam int FSW_W = 16;
    localparam int FRAME_TYPE_POS = 15;
    localparam int BLOCK_MOVE_POS = 14;
    localparam int ZERO_POS = 13;
    localparam int TRACE_POS = 12;
    localparam int EXT_BKPT_POS = 11;
    localparam int INT_BKPT_POS = 10;
    localparam int RERUN_POS = 9;
    localparam int LOCKED_POS = 8;
    localparam int PREFETCH_POS = 7;
    localparam int READ_POS = 6;
    localparam int LONG_POS = 5;
    localparam int SIZE_HI = 4;
    localparam int SIZE_LO = 3;
    localparam int FC_HI = 2;
    localparam int FC_LO = 0;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_RSVD = 2'h3;
    localparam logic FRAME_OPERAND = 1'b0;
    localparam logic FRAME_EXCEPTION = 1'b1;
    localparam logic [15:0] FSW_RESET = 16'h0000;
    localparam int FRAME_WORDS = 8;
    localparam int FRAME_AW = 3;
    // frame word slots written into the store
    localparam logic [2:0] SLOT_FSW = 3'h0;
    localparam logic [2:0] SLOT_PC_HI = 3'h1;
    localparam logic [2:0] SLOT_PC_LO = 3'h2;
    localparam logic [2:0] SLOT_SR = 3'h3;
    localparam logic [2:0] SLOT_ADDR_HI = 3'h4;
    localparam logic [2:0] SLOT_ADDR_LO = 3'h5;
    localparam logic [2:0] SLOT_DATA_HI = 3'h6;
    localparam logic [2:0] SLOT_DATA_LO = 3'h7;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PEND = 3'b001,
        ST_STACK = 3'b010,
        ST_DONE = 3'b011
    } stack_state_t;
endpackage : fault_status_pkg

// >>> frame_store.sv
// small frame store holding one bus error frame of 16-bit words
// assumes: one write and one read port, read data registered
`timescale 1ns/1ps
module frame_store (
    input wire logic core_clk, // processor clock
    input wire logic we, // write strobe
    input wire logic [2:0] waddr, // write slot
    input wire logic [15:0] wdata, // write word
    input wire logic [2:0] raddr, // read slot
    output logic [15:0] rdata // registered read word
);
    logic [15:0] mem [0:7];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        rdata <= mem[raddr];
    end
endmodule : frame_store

// >>> bus_fault_status_stacking.sv
// bus fault classification and fault status word stacking unit
// assumes: the bus controller gives fault attributes with a one-cycle
// fault strobe; the sequencer supplies boundary and operand-access strobes
// Notes on behaviour
// - status word: type, block move, zero, trace, bkpts, rerun, flags, size, fc
// - frame type 0 for operand or prefetch fault, 1 in exception processing
// - block move flag set during multi-register operand transfer or refetch
// - trace pending stacked, also for block-move and released-write faults
// - external and internal breakpoint pending kept in separate flags
// - rerun set only for released write; rerun on return if stacked set
// - locked flag set for faulted read-modify-write; ignored on unstack
// - prefetch flag 1 for prefetch, 0 for operand; ignored on unstack
// - direction 1 for read or prefetch, 0 write; reloaded when rerun set; unit stacks 1 for any exception-processing fault
// - long flag set for original long operand; ignored on unstack
// - size 00 long, 01 byte, 10 word; reloaded when rerun set
// - function code copied from cycle; reloaded when rerun set
// - unused bits stacked zero and ignored on unstack
// - released-write fault taken at next instruction boundary with next pc
// - operand access with released-write fault pending aborts, takes fault
// - released write: top bits zero, rerun 1, locked/prefetch/direction 0
// - released write also stacks next pc, sr, fault address, output data
// - prefetch, read, rmw, peripheral move are type II; last writes released
// - type II raises exception at once, aborts, restores address register
// - type II: frame type, block move, trace, rerun all zero
// - type II still stacks both breakpoint pending flags
// - rmw fault sets locked flag, direction shows read or write portion
// - block move fault aborts at once without restoring registers
`timescale 1ns/1ps
module bus_fault_status_stacking (
    input wire logic core_clk, // processor clock
    input wire logic rstn, // async reset, active low
    input wire logic bus_error_input, // faulted cycle strobe
    input wire logic cyc_read, // faulted cycle was a read
    input wire logic cyc_prefetch, // faulted cycle was a prefetch
    input wire logic cyc_locked, // faulted cycle part of rmw
    input wire logic cyc_released, // faulted cycle was a released write
    input wire logic cyc_in_exception, // fault during exception stacking
    input wire logic cyc_block_move, // block move operand transfer active
    input wire logic cyc_long, // original operand long word
    input wire logic [1:0] cyc_size, // remaining size
    input wire logic [2:0] function_code_lines, // fc of cycle
    input wire logic [31:0] cyc_addr, // faulted address
    input wire logic [31:0] cyc_data, // output data buffer
    input wire logic trace_pending, // trace exception pending
    input wire logic ext_bkpt_pending, // channel 1 breakpoint pending
    input wire logic int_bkpt_pending, // channel 0 breakpoint pending
    input wire logic instr_boundary, // instruction boundary strobe
    input wire logic operand_access, // new instruction operand access
    input wire logic [31:0] next_pc, // pc of next unexecuted instruction
    input wire logic [15:0] cur_sr, // current status register
    input wire logic unstack, // return from exception strobe
    input wire logic [15:0] unstack_fsw, // status word read back from stack
    input wire logic [2:0] rd_slot, // frame store read slot
    output logic [15:0] rd_word, // frame store read word
    output logic [15:0] fault_status_word, // last stacked word
    output logic take_exception, // pulse: start bus error exception
    output logic abort_instr, // pulse: abort current instruction
    output logic restore_areg, // pulse: undo postinc/predec
    output logic stack_busy, // frame being written
    output logic stack_done, // pulse: frame complete
    output logic write_pending, // released-write fault pending
    output logic rerun_req, // pulse: rerun bus cycle on return
    output logic rerun_read, // reloaded direction
    output logic [1:0] rerun_size, // reloaded size
    output logic [2:0] rerun_fc // reloaded function code
);
    import fault_status_pkg::*;

    stack_state_t state_r;
    logic [15:0] fsw_r;
    logic [15:0] fsw_nxt;
    logic [15:0] fsw_out_r;
    logic [2:0] slot_r;
    logic [31:0] addr_r;
    logic [31:0] data_r;
    logic [31:0] pc_r;
    logic [15:0] sr_r;
    logic pend_r;
    logic take_r;
    logic abort_r;
    logic restore_r;
    logic done_r;
    logic rerun_req_r;
    logic rerun_read_r;
    logic [1:0] rerun_size_r;
    logic [2:0] rerun_fc_r;
    logic [15:0] slot_word;
    logic type2;
    logic fire_released;
    logic take_type2;
    logic take_now;
    logic store_we;
    logic busy_r;

    // released write waits; everything else is immediate
    assign type2 = bus_error_input && !cyc_released;
    assign fire_released = pend_r && state_r == ST_PEND
        && (instr_boundary || operand_access);
    // a fault is accepted only while idle; later ones are dropped
    assign take_type2 = type2 && state_r == ST_IDLE;
    assign take_now = take_type2 || fire_released;
    // one frame word per cycle while the slot counter walks the frame
    assign store_we = state_r == ST_STACK;

    // word built from attributes; reserved bits forced zero
    always_comb begin
        fsw_nxt = FSW_RESET;
        fsw_nxt[FRAME_TYPE_POS] = cyc_in_exception ? FRAME_EXCEPTION
            : FRAME_OPERAND;
        fsw_nxt[BLOCK_MOVE_POS] = cyc_block_move && !cyc_released
            && !cyc_in_exception;
        fsw_nxt[ZERO_POS] = 1'b0;
        // type II restarts, so trace is requeued rather than stacked
        fsw_nxt[TRACE_POS] = trace_pending
            && (cyc_released || cyc_block_move
            || cyc_in_exception);
        fsw_nxt[EXT_BKPT_POS] = ext_bkpt_pending;
        fsw_nxt[INT_BKPT_POS] = int_bkpt_pending;
        fsw_nxt[RERUN_POS] = cyc_released && !cyc_in_exception;
        fsw_nxt[LOCKED_POS] = cyc_locked && !cyc_released;
        fsw_nxt[PREFETCH_POS] = cyc_prefetch && !cyc_released;
        fsw_nxt[READ_POS] = (cyc_read || cyc_prefetch) && !cyc_released
            || cyc_in_exception;
        fsw_nxt[LONG_POS] = cyc_long;
        // byte not legal when original operand was long
        fsw_nxt[SIZE_HI:SIZE_LO] = (cyc_size == SIZE_RSVD
            || (cyc_long && cyc_size == SIZE_BYTE)) ? SIZE_WORD
            : cyc_size;
        fsw_nxt[FC_HI:FC_LO] = function_code_lines;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            slot_r <= SLOT_FSW;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (type2) begin
                        state_r <= ST_STACK;
                        slot_r <= SLOT_FSW;
                    end else if (bus_error_input) begin
                        state_r <= ST_PEND;
                    end
                end
                ST_PEND: begin
                    if (fire_released) begin
                        state_r <= ST_STACK;
                        slot_r <= SLOT_FSW;
                    end
                end
                ST_STACK: begin
                    slot_r <= slot_r + 3'h1;
                    if (slot_r == SLOT_DATA_LO) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // attributes held from fault until the frame is written
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fsw_r <= FSW_RESET;
            addr_r <= 32'h0000_0000;
            data_r <= 32'h0000_0000;
        end else if (bus_error_input && state_r == ST_IDLE) begin
            fsw_r <= fsw_nxt;
            addr_r <= cyc_addr;
            data_r <= cyc_data;
        end else if (fire_released) begin
            // pending bits sampled when the exception is actually taken
            fsw_r[TRACE_POS] <= trace_pending;
            fsw_r[EXT_BKPT_POS] <= ext_bkpt_pending;
            fsw_r[INT_BKPT_POS] <= int_bkpt_pending;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pc_r <= 32'h0000_0000;
            sr_r <= 16'h0000;
        end else if (take_now) begin
            pc_r <= next_pc;
            sr_r <= cur_sr;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pend_r <= 1'b0;
        end else if (bus_error_input && cyc_released && state_r == ST_IDLE) begin
            pend_r <= 1'b1;
        end else if (fire_released) begin
            pend_r <= 1'b0;
        end
    end

    // 32-bit values go high word first so the handler reads them in order
    always_comb begin
        unique case (slot_r)
            SLOT_FSW: slot_word = fsw_r;
            SLOT_PC_HI: slot_word = pc_r[31:16];
            SLOT_PC_LO: slot_word = pc_r[15:0];
            SLOT_SR: slot_word = sr_r;
            SLOT_ADDR_HI: slot_word = addr_r[31:16];
            SLOT_ADDR_LO: slot_word = addr_r[15:0];
            SLOT_DATA_HI: slot_word = data_r[31:16];
            SLOT_DATA_LO: slot_word = data_r[15:0];
        endcase
    end

    frame_store u_store (
        .core_clk(core_clk),
        .we(store_we),
        .waddr(slot_r),
        .wdata(slot_word),
        .raddr(rd_slot),
        .rdata(rd_word)
    );

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            take_r <= 1'b0;
            abort_r <= 1'b0;
            restore_r <= 1'b0;
        end else begin
            take_r <= take_now;
            // abort for type II and for an access racing a pending write
            abort_r <= take_type2
                || fire_released && operand_access;
            // block moves keep altered registers as they are
            restore_r <= take_type2 && !cyc_block_move
                && !cyc_in_exception;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= state_r == ST_STACK && slot_r == SLOT_DATA_LO;
        end
    end

    // word held for the handler until the next frame overwrites it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fsw_out_r <= FSW_RESET;
        end else if (state_r == ST_STACK && slot_r == SLOT_FSW) begin
            fsw_out_r <= fsw_r;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rerun_req_r <= 1'b0;
        end else begin
            rerun_req_r <= unstack && unstack_fsw[RERUN_POS];
        end
    end

    // unstack: only direction, size, fc reload; other bits disregarded
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rerun_read_r <= 1'b0;
            rerun_size_r <= SIZE_LONG;
            rerun_fc_r <= 3'h0;
        end else if (unstack && unstack_fsw[RERUN_POS]) begin
            rerun_read_r <= unstack_fsw[READ_POS];
            rerun_size_r <= unstack_fsw[SIZE_HI:SIZE_LO];
            rerun_fc_r <= unstack_fsw[FC_HI:FC_LO];
        end
    end

    // busy rises with the take pulse so faults behind it are refused
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= state_r == ST_STACK && slot_r != SLOT_DATA_LO
                || take_now;
        end
    end

    assign fault_status_word = fsw_out_r;
    assign take_exception = take_r;
    assign abort_instr = abort_r;
    assign restore_areg = restore_r;
    assign stack_busy = busy_r;
    assign stack_done = done_r;
    assign write_pending = pend_r;
    assign rerun_req = rerun_req_r;
    assign rerun_read = rerun_read_r;
    assign rerun_size = rerun_size_r;
    assign rerun_fc = rerun_fc_r;
endmodule : bus_fault_status_stacking

// >>> fault_stack_asserts.sv
// checker for the fault status stacking unit
// assumes: bound to bus_fault_status_stacking, sees only its ports
`timescale 1ns/1ps
module fault_stack_asserts
    import fault_status_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rstn, // reset, low
    input wire logic bus_error_input, // fault strobe
    input wire logic cyc_released, // released write
    input wire logic cyc_in_exception, // exception fault
    input wire logic cyc_block_move, // block move
    input wire logic [2:0] function_code_lines, // fc
    input wire logic instr_boundary, // boundary
    input wire logic operand_access, // operand access
    input wire logic unstack, // return strobe
    input wire logic [15:0] unstack_fsw, // word read back
    input wire logic [15:0] fault_status_word, // stacked word
    input wire logic take_exception, // take pulse
    input wire logic abort_instr, // abort pulse
    input wire logic restore_areg, // restore pulse
    input wire logic stack_busy, // busy
    input wire logic stack_done, // done pulse
    input wire logic write_pending, // pending
    input wire logic rerun_req, // rerun pulse
    input wire logic rerun_read, // direction
    input wire logic [1:0] rerun_size, // size
    input wire logic [2:0] rerun_fc // fc
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic accept;
    logic [15:0] fsw_d;
    // faults while busy are dropped, so only idle ones count
    assign accept = bus_error_input && !stack_busy && !write_pending &&
        !take_exception && !stack_done;
    always_ff @(posedge core_clk) begin
        fsw_d <= unstack_fsw;
    end
    sequence type2_fault;
        accept && !cyc_released;
    endsequence
    sequence frame_write;
        stack_busy [*8] ##1 stack_done;
    endsequence
    take_immediate_a: assert property (
        type2_fault |=> take_exception && abort_instr)
        else $error("fault not taken at once");
    restore_select_a: assert property (
        type2_fault |=> restore_areg != $past(cyc_block_move ||
            cyc_in_exception))
        else $error("address register restore wrong");
    release_defer_a: assert property (
        accept && cyc_released |=> write_pending && !take_exception)
        else $error("released write not deferred");
    boundary_take_a: assert property (
        write_pending && (instr_boundary || operand_access) |=>
            take_exception && !write_pending &&
            abort_instr == $past(operand_access))
        else $error("pending write not taken");
    frame_length_a: assert property (
        take_exception |-> frame_write)
        else $error("frame stacking length wrong");
    type2_word_a: assert property (
        type2_fault and (!cyc_in_exception && !cyc_block_move) |-> ##2
            fault_status_word[15:12] == 4'h0 &&
            !fault_status_word[RERUN_POS] &&
            fault_status_word[2:0] == $past(function_code_lines, 2))
        else $error("type II status word wrong");
    released_word_a: assert property (
        write_pending && (instr_boundary || operand_access) |-> ##2
            fault_status_word[15:13] == 3'h0 &&
            fault_status_word[9:6] == 4'h8)
        else $error("released status word wrong");
    rerun_reload_a: assert property (
        unstack && unstack_fsw[RERUN_POS] |=> rerun_req &&
            {rerun_read, rerun_size, rerun_fc} == {fsw_d[6], fsw_d[4:0]})
        else $error("rerun fields not reloaded");
    no_rerun_a: assert property (
        unstack && !unstack_fsw[RERUN_POS] |=> !rerun_req)
        else $error("rerun without flag");
endmodule : fault_stack_asserts

bind bus_fault_status_stacking fault_stack_asserts u_asserts (
    .core_clk(core_clk), .rstn(rstn), .bus_error_input(bus_error_input),
    .cyc_released(cyc_released), .cyc_in_exception(cyc_in_exception),
    .cyc_block_move(cyc_block_move), .instr_boundary(instr_boundary),
    .function_code_lines(function_code_lines), .unstack(unstack),
    .operand_access(operand_access), .unstack_fsw(unstack_fsw),
    .fault_status_word(fault_status_word), .abort_instr(abort_instr),
    .take_exception(take_exception), .restore_areg(restore_areg),
    .stack_busy(stack_busy), .stack_done(stack_done),
    .write_pending(write_pending), .rerun_req(rerun_req),
    .rerun_read(rerun_read), .rerun_size(rerun_size), .rerun_fc(rerun_fc));

// >>> bus_ctrl_model.sv
// model of the bus controller reporting faulted cycles
// assumes: the bench calls fault() just after a clock edge
`timescale 1ns/1ps
module bus_ctrl_model (
    input wire logic core_clk, // clock
    output logic bus_error_input, // fault strobe
    output logic cyc_read, // read
    output logic cyc_prefetch, // prefetch
    output logic cyc_locked, // rmw
    output logic cyc_released, // released write
    output logic cyc_in_exception, // exception fault
    output logic cyc_block_move, // block move
    output logic cyc_long, // long operand
    output logic [1:0] cyc_size, // remaining size
    output logic [2:0] function_code_lines, // fc
    output logic [31:0] cyc_addr, // address
    output logic [31:0] cyc_data // data buffer
);
    logic [75:0] attr = '0;
    initial bus_error_input = 1'b0;
    assign {cyc_read, cyc_prefetch, cyc_locked, cyc_released,
        cyc_in_exception, cyc_block_move, cyc_long, cyc_size,
        function_code_lines, cyc_addr, cyc_data} = attr;
    task automatic fault(input int k, input logic [15:0] r,
        input logic [31:0] a, input logic [31:0] d, input int dly);
        repeat (dly) @(posedge core_clk);
        @(posedge core_clk);
        bus_error_input <= 1'b1;
        attr <= {k == 1 || k == 4 || k == 5 || (k != 3 && r[0]),
            k == 1 || (k == 5 && r[0]), k == 2, k == 3, k == 4, k == 5,
            r[1], r[3:2], r[9:7], a, d};
        @(posedge core_clk);
        bus_error_input <= 1'b0;
        // stale attributes must not look valid
        attr <= ~attr;
    endtask : fault
endmodule : bus_ctrl_model

// >>> test_bus_fault_status_stacking.sv
// self-checking bench for the fault status stacking unit
// assumes: bus_ctrl_model and the checker are compiled first
`timescale 1ns/1ps
module test_bus_fault_status_stacking;
    import fault_status_pkg::*;
    logic core_clk, rstn, trace_pending, ext_bkpt_pending, int_bkpt_pending;
    logic instr_boundary, operand_access, unstack;
    logic [31:0] next_pc, cyc_addr, cyc_data, r, a, d, p;
    logic [15:0] cur_sr, unstack_fsw, rd_word, fault_status_word, uw;
    logic [15:0] w [8];
    logic bus_error_input, cyc_read, cyc_prefetch, cyc_locked, cyc_released;
    logic cyc_in_exception, cyc_block_move, cyc_long;
    logic [1:0] cyc_size, rerun_size;
    logic [2:0] function_code_lines, rd_slot, rerun_fc;
    logic take_exception, abort_instr, restore_areg, stack_busy, stack_done;
    logic write_pending, rerun_req, rerun_read;
    int n_errors = 0, checks_done = 0, cycles = 0, seed = 49, i, s;
    bus_fault_status_stacking u_bus_fault_status_stacking (.*);
    bus_ctrl_model u_bus_ctrl_model (.*);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    function automatic logic [15:0] exp_fsw(input int k, input logic [31:0] r);
        logic [1:0] sz;
        sz = r[3:2];
        // reserved size and byte of a long read back as word
        if (sz == SIZE_RSVD || (sz == SIZE_BYTE && r[1]))
            sz = SIZE_WORD;
        return {k == 4, k == 5, 1'b0, k >= 3 && r[4], r[5], r[6], k == 3,
            k == 2, k == 1 || (k == 5 && r[0]),
            k == 1 || k == 4 || k == 5 || (k < 3 && r[0]), r[1], sz, r[9:7]};
    endfunction : exp_fsw
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_hi(input int which);
        int n;
        n = 0;
        // pulses stand one cycle: look once the launching edge has settled
        #1;
        while ((which ? stack_done : take_exception) !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 40)
            chk(16'h0000, 16'h0001);
    endtask : wait_hi
    task automatic run_case(input int k);
        r = $random(seed);
        a = $random(seed);
        d = $random(seed);
        p = a ^ d;
        @(posedge core_clk);
        trace_pending <= r[4];
        ext_bkpt_pending <= r[5];
        int_bkpt_pending <= r[6];
        next_pc <= p;
        cur_sr <= r[31:16];
        u_bus_ctrl_model.fault(k, r[15:0], a, d, r[11:10]);
        if (k == 3) begin
            repeat (1 + r[13:12]) @(posedge core_clk);
            #1;
            chk(write_pending, 1'b1);
            @(posedge core_clk);
            instr_boundary <= !r[14];
            operand_access <= r[14];
            @(posedge core_clk);
            instr_boundary <= 1'b0;
            operand_access <= 1'b0;
        end
        wait_hi(0);
        chk(abort_instr, k != 3 || r[14]);
        wait_hi(1);
        w = '{exp_fsw(k, r), p[31:16], p[15:0], r[31:16], a[31:16], a[15:0],
            d[31:16], d[15:0]};
        chk(fault_status_word, w[0]);
        for (s = 0; s < 8; s++) begin
            @(posedge core_clk);
            rd_slot <= s[2:0];
            repeat (2) @(posedge core_clk);
            #1;
            chk(rd_word, w[s]);
        end
    endtask : run_case
    task automatic do_unstack(input logic [15:0] u);
        @(posedge core_clk);
        unstack <= 1'b1;
        unstack_fsw <= u;
        @(posedge core_clk);
        unstack <= 1'b0;
        unstack_fsw <= ~u;
        // the reload pulse stands only in the cycle after the strobe
        #1;
        chk(rerun_req, u[RERUN_POS]);
        if (u[RERUN_POS])
            chk({rerun_read, rerun_size, rerun_fc}, {u[6], u[4:0]});
    endtask : do_unstack
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude;
        end
    end
    initial begin
        {rstn, trace_pending, ext_bkpt_pending, int_bkpt_pending} = 4'h0;
        {instr_boundary, operand_access, unstack} = 3'h0;
        next_pc = 32'h0000_0000;
        cur_sr = 16'h0000;
        unstack_fsw = 16'h0000;
        rd_slot = 3'h0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1;
        chk(fault_status_word, FSW_RESET);
        chk({stack_busy, write_pending, take_exception}, 16'h0000);
        // every fault kind, several random attribute sets each
        for (i = 0; i < 30; i++)
            run_case(i % 6);
        for (i = 0; i < 8; i++) begin
            s = $random(seed);
            uw = s[15:0];
            uw[RERUN_POS] = i[0];
            do_unstack(uw);
        end
        conclude;
    end
endmodule : test_bus_fault_status_stacking
